// ==== aer_pkg.sv ====
// Package for the advanced error reporting register bank.
// Assumes a plain strobe register port with 12-bit byte addresses.
package aer_pkg;

	localparam int unsigned AER_ADDR_W = 12;
	localparam int unsigned AER_DATA_W = 32;

	// Byte offsets
	localparam logic [11:0] AER_OFS_UNC_STATUS = 12'h104;
	localparam logic [11:0] AER_OFS_UNC_SEVERITY = 12'h10C;
	localparam logic [11:0] AER_OFS_COR_STATUS = 12'h110;
	localparam logic [11:0] AER_OFS_COR_MASK = 12'h114;
	localparam logic [11:0] AER_OFS_CAPS_CTRL = 12'h118;
	localparam logic [11:0] AER_OFS_HDR_LOG0 = 12'h11C;
	localparam logic [11:0] AER_OFS_HDR_LOG1 = 12'h120;
	localparam logic [11:0] AER_OFS_HDR_LOG2 = 12'h124;
	localparam logic [11:0] AER_OFS_HDR_LOG3 = 12'h128;
	localparam logic [11:0] AER_OFS_SEC_STATUS = 12'h12C;
	localparam logic [11:0] AER_OFS_SEC_MASK = 12'h130;
	localparam logic [11:0] AER_OFS_INT_MASK = 12'h1F0;

	// Implemented bits and reset values of the registers
	localparam logic [31:0] AER_UNC_BITS = 32'h001F_F011;
	localparam logic [31:0] AER_UNC_SEV_RESET = 32'h0006_2011;
	localparam logic [31:0] AER_COR_BITS = 32'h0000_11C1;
	localparam logic [31:0] AER_COR_MASK_RESET = 32'h0000_0000;
	localparam logic [31:0] AER_SEC_BITS = 32'h0000_3FEF;
	localparam logic [31:0] AER_SEC_MASK_RESET = 32'h0000_17A8;
	localparam logic [31:0] AER_STAT_RESET = 32'h0000_0000;

	// Capabilities and control fields
	localparam int unsigned AER_FEP_LSB = 0;
	localparam int unsigned AER_FEP_W = 5;
	localparam int unsigned AER_ECRC_GEN_CAP_BIT = 5;
	localparam int unsigned AER_ECRC_GEN_EN_BIT = 6;
	localparam int unsigned AER_ECRC_CHK_CAP_BIT = 7;
	localparam int unsigned AER_ECRC_CHK_EN_BIT = 8;
	localparam logic [4:0] AER_FEP_RESET = 5'h00;

	localparam int unsigned AER_HDR_WORDS = 4;
	localparam logic [31:0] AER_HDR_RESET = 32'h0000_0000;

	// Interrupt mask register: bit0 uncorrectable, bit1 correctable,
	// bit2 secondary
	localparam logic [2:0] AER_INT_MASK_RESET = 3'h0;

endpackage

// ==== aer_regs.sv ====
// Advanced error reporting register bank of the bridge.
// Assumes error sources pulse i_*_set for one cycle, and that power-on
// reset and conventional reset are separate synchronous inputs.
//
// Summary of operation
// - Uncorrectable severity sticky, reset 0,4,13,17,18 set
// - Correctable status flags sticky, write one clears
// - Correctable mask sticky read-write, resets to zero
// - First error pointer sticky read-only, loaded on first uncorrectable error
// - ECRC capable bits one; enables sticky read-write
// - Four header words, byte zero in top bits
// - Secondary status flags sticky, write one clears
// - Secondary mask sticky, some bits reset masked
// - Uncorrectable status sticky write one clears
`timescale 1ns/10ps
module aer_regs
(
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_por,
	input wire logic [aer_pkg::AER_ADDR_W-1:0] i_addr,
	input wire logic [aer_pkg::AER_DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [aer_pkg::AER_DATA_W-1:0] o_rdata,
	input wire logic [31:0] i_unc_set,
	input wire logic [31:0] i_cor_set,
	input wire logic [31:0] i_sec_set,
	input wire logic [4:0] i_first_err_ptr,
	input wire logic [127:0] i_hdr_bytes,
	output logic o_ecrc_gen_en,
	output logic o_ecrc_chk_en,
	output logic [31:0] o_unc_severity,
	output logic o_irq
);
	import aer_pkg::*;

	////////////////////////////////////////////////////////////////////
	// State
	logic [31:0] unc_status_reg, unc_status_next;
	logic [31:0] unc_sev_reg, unc_sev_next;
	logic [31:0] cor_status_reg, cor_status_next;
	logic [31:0] cor_mask_reg, cor_mask_next;
	logic [31:0] sec_status_reg, sec_status_next;
	logic [31:0] sec_mask_reg, sec_mask_next;
	logic [4:0] fep_reg, fep_next;
	logic gen_en_reg, gen_en_next;
	logic chk_en_reg, chk_en_next;
	logic [31:0] hdr_reg [AER_HDR_WORDS];
	logic [31:0] hdr_next [AER_HDR_WORDS];
	logic [2:0] int_mask_reg, int_mask_next;
	logic [31:0] rdata_reg, rdata_next;
	logic irq_reg, irq_next;
	logic [31:0] unc_new;

	////////////////////////////////////////////////////////////////////
	// Write decode, one strobe per writable register
	logic wr_unc_status, wr_unc_sev, wr_cor_status, wr_cor_mask;
	logic wr_caps, wr_sec_status, wr_sec_mask, wr_int_mask;
	logic log_load;
	logic unc_pending, cor_pending, sec_pending;

	// Unmapped addresses decode to no strobe, so such writes vanish
	always_comb
	begin
		wr_unc_status = i_wr && (i_addr == AER_OFS_UNC_STATUS);
		wr_unc_sev = i_wr && (i_addr == AER_OFS_UNC_SEVERITY);
		wr_cor_status = i_wr && (i_addr == AER_OFS_COR_STATUS);
		wr_cor_mask = i_wr && (i_addr == AER_OFS_COR_MASK);
		wr_caps = i_wr && (i_addr == AER_OFS_CAPS_CTRL);
		wr_sec_status = i_wr && (i_addr == AER_OFS_SEC_STATUS);
		wr_sec_mask = i_wr && (i_addr == AER_OFS_SEC_MASK);
		wr_int_mask = i_wr && (i_addr == AER_OFS_INT_MASK);
	end

	////////////////////////////////////////////////////////////////////
	// Uncorrectable severity
	always_comb
	begin
		unc_sev_next = unc_sev_reg;
		if (wr_unc_sev)
		begin
			unc_sev_next = i_wdata & AER_UNC_BITS;
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (i_por)
		begin
			unc_sev_reg <= AER_UNC_SEV_RESET;
		end
		else
		begin
			unc_sev_reg <= unc_sev_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Uncorrectable status
	always_comb
	begin
		unc_new = i_unc_set & AER_UNC_BITS;
		unc_status_next = unc_status_reg;
		if (wr_unc_status)
		begin
			unc_status_next = unc_status_reg & ~i_wdata;
		end
		// Set wins, so an event is never lost to a racing clear
		unc_status_next = unc_status_next | unc_new;
	end

	always_ff @(posedge i_clock)
	begin
		if (i_por)
		begin
			unc_status_reg <= AER_STAT_RESET;
		end
		else
		begin
			unc_status_reg <= unc_status_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Correctable status
	always_comb
	begin
		cor_status_next = cor_status_reg;
		if (wr_cor_status)
		begin
			cor_status_next = cor_status_reg & ~i_wdata;
		end
		cor_status_next = cor_status_next | (i_cor_set & AER_COR_BITS);
	end

	always_ff @(posedge i_clock)
	begin
		if (i_por)
		begin
			cor_status_reg <= AER_STAT_RESET;
		end
		else
		begin
			cor_status_reg <= cor_status_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Correctable mask
	always_comb
	begin
		cor_mask_next = cor_mask_reg;
		if (wr_cor_mask)
		begin
			cor_mask_next = i_wdata & AER_COR_BITS;
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (i_por)
		begin
			cor_mask_reg <= AER_COR_MASK_RESET;
		end
		else
		begin
			cor_mask_reg <= cor_mask_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// ECRC enables; the capable bits are constants in the read path
	always_comb
	begin
		gen_en_next = gen_en_reg;
		chk_en_next = chk_en_reg;
		if (wr_caps)
		begin
			gen_en_next = i_wdata[AER_ECRC_GEN_EN_BIT];
			chk_en_next = i_wdata[AER_ECRC_CHK_EN_BIT];
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (i_por)
		begin
			gen_en_reg <= 1'b0;
			chk_en_reg <= 1'b0;
		end
		else
		begin
			gen_en_reg <= gen_en_next;
			chk_en_reg <= chk_en_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Secondary status
	always_comb
	begin
		sec_status_next = sec_status_reg;
		if (wr_sec_status)
		begin
			sec_status_next = sec_status_reg & ~i_wdata;
		end
		sec_status_next = sec_status_next | (i_sec_set & AER_SEC_BITS);
	end

	always_ff @(posedge i_clock)
	begin
		if (i_por)
		begin
			sec_status_reg <= AER_STAT_RESET;
		end
		else
		begin
			sec_status_reg <= sec_status_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Secondary mask
	always_comb
	begin
		sec_mask_next = sec_mask_reg;
		if (wr_sec_mask)
		begin
			sec_mask_next = i_wdata & AER_SEC_BITS;
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (i_por)
		begin
			sec_mask_reg <= AER_SEC_MASK_RESET;
		end
		else
		begin
			sec_mask_reg <= sec_mask_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// First error pointer and header log. Only the first error while
	// nothing is pending loads them; software must clear the status
	// before a new header can be captured.
	always_comb
	begin
		log_load = (unc_new != 32'h0000_0000)
			&& (unc_status_reg == 32'h0000_0000);
		fep_next = fep_reg;
		for (int w = 0; w < AER_HDR_WORDS; w++)
		begin
			hdr_next[w] = hdr_reg[w];
		end
		if (log_load)
		begin
			fep_next = i_first_err_ptr;
			for (int w = 0; w < AER_HDR_WORDS; w++)
			begin
				// Byte 4w sits in bits 31:24 of word w
				hdr_next[w] = i_hdr_bytes[127-32*w -: 32];
			end
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (i_por)
		begin
			fep_reg <= AER_FEP_RESET;
			for (int w = 0; w < AER_HDR_WORDS; w++)
			begin
				hdr_reg[w] <= AER_HDR_RESET;
			end
		end
		else
		begin
			fep_reg <= fep_next;
			for (int w = 0; w < AER_HDR_WORDS; w++)
			begin
				hdr_reg[w] <= hdr_next[w];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Interrupt enables: not sticky, either reset clears them
	always_comb
	begin
		int_mask_next = int_mask_reg;
		if (wr_int_mask)
		begin
			int_mask_next = i_wdata[2:0];
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (i_por || i_rst)
		begin
			int_mask_reg <= AER_INT_MASK_RESET;
		end
		else
		begin
			int_mask_reg <= int_mask_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Interrupt level, built from next values so it follows a write
	// or an event at the same edge as the registers themselves
	always_comb
	begin
		unc_pending = unc_status_next != 32'h0000_0000;
		cor_pending = (cor_status_next & ~cor_mask_next) != 32'h0000_0000;
		sec_pending = (sec_status_next & ~sec_mask_next) != 32'h0000_0000;
		irq_next = (int_mask_next[0] && unc_pending)
			|| (int_mask_next[1] && cor_pending)
			|| (int_mask_next[2] && sec_pending);
	end

	always_ff @(posedge i_clock)
	begin
		if (i_por || i_rst)
		begin
			irq_reg <= 1'b0;
		end
		else
		begin
			irq_reg <= irq_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read data: valid for the one cycle after the strobe, else zero
	always_comb
	begin
		rdata_next = 32'h0000_0000;
		if (i_rd)
		begin
			unique case (i_addr)
				AER_OFS_UNC_STATUS: rdata_next = unc_status_reg;
				AER_OFS_UNC_SEVERITY: rdata_next = unc_sev_reg;
				AER_OFS_COR_STATUS: rdata_next = cor_status_reg;
				AER_OFS_COR_MASK: rdata_next = cor_mask_reg;
				AER_OFS_CAPS_CTRL:
				begin
					rdata_next[AER_FEP_LSB +: AER_FEP_W] = fep_reg;
					rdata_next[AER_ECRC_GEN_CAP_BIT] = 1'b1;
					rdata_next[AER_ECRC_GEN_EN_BIT] = gen_en_reg;
					rdata_next[AER_ECRC_CHK_CAP_BIT] = 1'b1;
					rdata_next[AER_ECRC_CHK_EN_BIT] = chk_en_reg;
				end
				AER_OFS_HDR_LOG0: rdata_next = hdr_reg[0];
				AER_OFS_HDR_LOG1: rdata_next = hdr_reg[1];
				AER_OFS_HDR_LOG2: rdata_next = hdr_reg[2];
				AER_OFS_HDR_LOG3: rdata_next = hdr_reg[3];
				AER_OFS_SEC_STATUS: rdata_next = sec_status_reg;
				AER_OFS_SEC_MASK: rdata_next = sec_mask_reg;
				AER_OFS_INT_MASK: rdata_next = {29'h0, int_mask_reg};
				default: rdata_next = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (i_por || i_rst)
		begin
			rdata_reg <= 32'h0000_0000;
		end
		else
		begin
			rdata_reg <= rdata_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Output mirrors of sticky control state. They drop during a hot
	// reset and pick the kept values up again one edge after it.
	always_ff @(posedge i_clock)
	begin
		if (i_por || i_rst)
		begin
			o_ecrc_gen_en <= 1'b0;
			o_ecrc_chk_en <= 1'b0;
			o_unc_severity <= 32'h0000_0000;
		end
		else
		begin
			o_ecrc_gen_en <= gen_en_next;
			o_ecrc_chk_en <= chk_en_next;
			o_unc_severity <= unc_sev_next;
		end
	end

	assign o_rdata = rdata_reg;
	assign o_irq = irq_reg;
endmodule

// ==== aer_regs_asserts.sv ====
// Checker for aer_regs: read port, severity mirror, control bits, irq.
// Sees only ports of aer_regs; bound from the bench top file.
`timescale 1ns/10ps
module aer_regs_checker
	import aer_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_por,
	input wire logic [aer_pkg::AER_ADDR_W-1:0] i_addr,
	input wire logic [aer_pkg::AER_DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [aer_pkg::AER_DATA_W-1:0] o_rdata,
	input wire logic o_ecrc_gen_en,
	input wire logic o_ecrc_chk_en,
	input wire logic [31:0] o_unc_severity,
	input wire logic o_irq
);
	// Mirrors refill after a reset, so some checks wait a few edges
	logic [2:0] up_reg;
	always_ff @(posedge i_clock)
		up_reg <= (i_rst || i_por) ? 3'h0 : up_reg + {2'h0, ~up_reg[2]};
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_rst || i_por);
	////////////////////////////////////////
	a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
		else $error("read data not zero outside a read");
	a_sev_read: assert property (up_reg[2] && $past(i_rd) &&
		$past(i_addr) == AER_OFS_UNC_SEVERITY |-> o_rdata == $past(o_unc_severity))
		else $error("severity read differs from mirror");
	a_sev_write: assert property (up_reg[2] && $past(i_wr) &&
		$past(i_addr) == AER_OFS_UNC_SEVERITY |->
		o_unc_severity == ($past(i_wdata) & 32'h001F_F011))
		else $error("severity write not taken");
	a_sev_hold: assert property (up_reg[2] && !($past(i_wr) &&
		$past(i_addr) == AER_OFS_UNC_SEVERITY) |-> $stable(o_unc_severity))
		else $error("severity changed without a write");
	a_caps_read: assert property ($past(i_rd) &&
		$past(i_addr) == AER_OFS_CAPS_CTRL |->
		o_rdata[7] && o_rdata[5] && o_rdata[31:9] == 23'h0)
		else $error("capability bits wrong");
	a_ecrc_write: assert property (up_reg[2] && $past(i_wr) &&
		$past(i_addr) == AER_OFS_CAPS_CTRL |-> o_ecrc_gen_en ==
		$past(i_wdata[6]) && o_ecrc_chk_en == $past(i_wdata[8]))
		else $error("ecrc enables not taken");
	a_cor_rsvd: assert property ($past(i_rd) &&
		$past(i_addr) == AER_OFS_COR_STATUS |->
		(o_rdata & 32'hFFFF_EE3E) == 32'h0)
		else $error("correctable reserved bits set");
	a_irq_fall: assert property ($fell(o_irq) |-> $past(i_wr))
		else $error("irq dropped without a write");
endmodule

// ==== aer_regs_tb_top.sv ====
// Bench for aer_regs: register port, error events, both resets.
// Assumes aer_pkg and the checker file are compiled first.
`timescale 1ns/10ps
module aer_regs_tb_top;
	import aer_pkg::*;
	logic i_clock = 1'b0, i_rst = 1'b1, i_por = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
	logic [11:0] i_addr = 12'h000;
	logic [31:0] i_wdata = 32'h0, i_unc_set = 32'h0, i_cor_set = 32'h0;
	logic [31:0] i_sec_set = 32'h0, o_rdata, o_unc_severity, d;
	logic [4:0] i_first_err_ptr = 5'h00;
	logic [127:0] i_hdr_bytes = 128'h0;
	logic o_ecrc_gen_en, o_ecrc_chk_en, o_irq;
	int n_errors = 0;
	int checks_done = 0;
	aer_regs dut (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_por(i_por),
		.i_addr(i_addr),
		.i_wdata(i_wdata),
		.i_wr(i_wr),
		.i_rd(i_rd),
		.o_rdata(o_rdata),
		.i_unc_set(i_unc_set),
		.i_cor_set(i_cor_set),
		.i_sec_set(i_sec_set),
		.i_first_err_ptr(i_first_err_ptr),
		.i_hdr_bytes(i_hdr_bytes),
		.o_ecrc_gen_en(o_ecrc_gen_en),
		.o_ecrc_chk_en(o_ecrc_chk_en),
		.o_unc_severity(o_unc_severity),
		.o_irq(o_irq)
	);
	////////////////////////////////////////
	function automatic logic [31:0] rst_val(input logic [11:0] a);
		case (a)
			12'h10C: return 32'h0006_2011;
			12'h118: return 32'h0000_00A0;
			12'h130: return 32'h0000_17A8;
			default: return 32'h0;
		endcase
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		@(posedge i_clock);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= v;
		@(posedge i_clock);
		i_wr <= 1'b0;
		#1;
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		@(posedge i_clock);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clock);
		i_rd <= 1'b0;
		#1;
		chk(o_rdata, e);
	endtask
	task automatic ev(input logic [31:0] u, input logic [31:0] c);
		@(posedge i_clock);
		i_unc_set <= u;
		i_cor_set <= c;
		i_sec_set <= c;
		@(posedge i_clock);
		i_unc_set <= 32'h0;
		i_cor_set <= 32'h0;
		i_sec_set <= 32'h0;
		#1;
	endtask
	task automatic pulse_rst(input logic por);
		@(posedge i_clock);
		i_rst <= 1'b1;
		i_por <= por;
		repeat (2) @(posedge i_clock);
		i_rst <= 1'b0;
		i_por <= 1'b0;
	endtask
	task automatic complete_run;
		$display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	////////////////////////////////////////
	initial
	begin
		forever #5 i_clock = ~i_clock;
	end
	initial
	begin
		repeat (3000) @(posedge i_clock);
		n_errors++;
		complete_run;
	end
	initial
	begin
		d = $urandom(32'hCAB1);
		repeat (4) @(posedge i_clock);
		i_rst <= 1'b0;
		i_por <= 1'b0;
		for (int a = 'h100; a <= 'h138; a += 4)
			rdc(12'(a), rst_val(12'(a)));
		for (int i = 0; i < 6; i++)
		begin
			d = (i == 0) ? 32'hFFFF_FFFF : $urandom;
			wr(AER_OFS_UNC_SEVERITY, d);
			chk(o_unc_severity, d & 32'h001F_F011);
			wr(AER_OFS_COR_MASK, d);
			rdc(AER_OFS_COR_MASK, d & 32'h0000_11C1);
			wr(AER_OFS_SEC_MASK, ~d);
			rdc(AER_OFS_SEC_MASK, ~d & 32'h0000_3FEF);
			wr(AER_OFS_CAPS_CTRL, d);
			rdc(AER_OFS_CAPS_CTRL, d & 32'h0000_0140 | 32'h0000_00A0);
			wr(AER_OFS_HDR_LOG2, d);
			rdc(AER_OFS_HDR_LOG2, 32'h0);
		end
		i_hdr_bytes <= {$urandom, $urandom, $urandom, $urandom};
		i_first_err_ptr <= 5'($urandom);
		ev(32'h0000_0010, 32'h0);
		rdc(AER_OFS_UNC_STATUS, 32'h0000_0010);
		for (int k = 0; k < 4; k++)
			rdc(12'(12'h11C + 4 * k), i_hdr_bytes[127 - 32 * k -: 32]);
		// Later errors must not move the pointer
		i_first_err_ptr <= ~i_first_err_ptr;
		ev(32'hFFFF_FFFF, 32'hFFFF_FFFF);
		rdc(AER_OFS_CAPS_CTRL, {d[31:9] & 23'h0, d[8], 1'b1, d[6], 1'b1,
			~i_first_err_ptr});
		rdc(AER_OFS_UNC_STATUS, 32'h001F_F011);
		rdc(AER_OFS_COR_STATUS, 32'h0000_11C1);
		rdc(AER_OFS_SEC_STATUS, 32'h0000_3FEF);
		wr(AER_OFS_SEC_STATUS, 32'h0000_0001);
		rdc(AER_OFS_SEC_STATUS, 32'h0000_3FEE);
		chk({31'h0, o_irq}, 32'h0);
		// Unmask every correctable source so the level depends on status
		wr(AER_OFS_COR_MASK, 32'h0);
		wr(AER_OFS_INT_MASK, 32'h0000_0002);
		chk({31'h0, o_irq}, 32'h1);
		wr(AER_OFS_COR_STATUS, 32'hFFFF_FFFF);
		chk({31'h0, o_irq}, 32'h0);
		ev(32'h0, 32'h0000_1000);
		chk({31'h0, o_irq}, 32'h1);
		wr(AER_OFS_INT_MASK, 32'h0000_0001);
		chk({31'h0, o_irq}, 32'h1);
		wr(AER_OFS_UNC_STATUS, 32'hFFFF_FFFF);
		chk({31'h0, o_irq}, 32'h0);
		rdc(AER_OFS_UNC_STATUS, 32'h0);
		pulse_rst(1'b0);
		rdc(AER_OFS_UNC_SEVERITY, d & 32'h001F_F011);
		rdc(AER_OFS_COR_STATUS, 32'h0000_1000);
		chk({31'h0, o_irq}, 32'h0);
		pulse_rst(1'b1);
		rdc(AER_OFS_UNC_SEVERITY, 32'h0006_2011);
		rdc(AER_OFS_COR_STATUS, 32'h0);
		complete_run;
	end
endmodule
bind aer_regs aer_regs_checker u_chk (.i_clock(i_clock), .i_rst(i_rst),
	.i_por(i_por), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
	.i_rd(i_rd), .o_rdata(o_rdata), .o_ecrc_gen_en(o_ecrc_gen_en),
	.o_ecrc_chk_en(o_ecrc_chk_en), .o_unc_severity(o_unc_severity),
	.o_irq(o_irq));
